// file: bench/mcu_bus_model.sv
// microcontroller bus model with separate code and data strobes
`timescale 1ns/1ps
module mcu_bus_model (
	// clock
	input wire logic core_clk_in,
	// read data from the device
	input wire logic [7:0] rdata_in,
	// bus drive
	output logic [19:0] addr_out,
	output logic [7:0] wdata_out,
	output logic write_strobe_out,
	output logic read_strobe_out,
	output logic code_fetch_strobe_out
);
	initial begin
		addr_out = 20'h00000;
		wdata_out = 8'h00;
		{code_fetch_strobe_out, read_strobe_out, write_strobe_out} = 3'b000;
	end

	// kind: 0 idle, 1 code fetch, 2 data read, 3 data write
	// map and power-mode writes may come at any time, each access followed by one released (idle) cycle
	task automatic access(input logic [1:0] kind, input logic [19:0] a, input logic [7:0] wd,
		output logic [7:0] rd);
		@(negedge core_clk_in);
		addr_out = a;
		wdata_out = wd;
		code_fetch_strobe_out = (kind == 2'd1);
		read_strobe_out = (kind == 2'd2);
		write_strobe_out = (kind == 2'd3);
		@(negedge core_clk_in);
		rd = rdata_in;
		// released lines flip so a stale copy can never look valid
		addr_out = ~addr_out;
		wdata_out = ~wdata_out;
		{code_fetch_strobe_out, read_strobe_out, write_strobe_out} = 3'b000;
	endtask : access
endmodule : mcu_bus_model

// file: bench/tb_memory_space_decoder.sv
// self-checking bench for the memory space decoder
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
	$display("[FAIL] %0t got %h want %h", $time, g, e); end end
module tb_memory_space_decoder
	import memory_space_decoder_pkg::*;
;
	typedef struct packed {byte_t map; logic [1:0] kind; logic [15:0] addr; logic [2:0] exp;} row_t;
	logic core_clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic [19:0] addr;
	logic [7:0] wdata, rdata, pa = 8'h00, fl_sel;
	logic wr_s, rd_s, cf_s, twenty = 1'b0, pwr_down = 1'b0, ready = 1'b1;
	logic [2:0] ctl = 3'b000;
	logic [8*3*73-1:0] fl_care = '0, fl_match = '0;
	logic [4*3*73-1:0] ee_care = '0, ee_match = '0;
	logic [2*73-1:0] sr_care = '0, sr_match = '0;
	logic [4*73-1:0] mi_care = {4{73'h1}}, mi_match = '0;
	logic [23:0] fl_en = '0;
	logic [11:0] ee_en = '0;
	logic [1:0] sr_en = '0, per_sel;
	logic [3:0] ee_sel;
	logic sr_sel, cfg_sel, jtag, standby;
	logic [72:0] abus;
	int num_errors = 0, checks = 0, cycles = 0;
	byte_t d;
	byte_t roff[4] = '{8'hE0, 8'hE1, 8'hB0, 8'hB4};
	byte_t rval[4] = '{8'h00, 8'h0C, 8'h08, 8'h00};
	// expected {sram, eeprom 0, flash 0}; flash over A15, eeprom 8000-BFFF, sram 8000-87FF
	row_t rows[10] = '{
		'{8'h0C, 2'd1, 16'hC000, 3'b001}, '{8'h0C, 2'd2, 16'hC000, 3'b000},
		'{8'h0C, 2'd2, 16'h9000, 3'b010}, '{8'h14, 2'd2, 16'hC000, 3'b001},
		'{8'h14, 2'd1, 16'hC000, 3'b001}, '{8'h0C, 2'd2, 16'h8000, 3'b100},
		'{8'h01, 2'd1, 16'h8000, 3'b100}, '{8'h1A, 2'd1, 16'h9000, 3'b010},
		'{8'h0C, 2'd0, 16'h8000, 3'b000}, '{8'h0C, 2'd3, 16'h9000, 3'b010}};

	always #4 core_clk_in = ~core_clk_in;

	mcu_bus_model mcu_bus_model_i (.core_clk_in, .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
		.write_strobe_out(wr_s), .read_strobe_out(rd_s), .code_fetch_strobe_out(cf_s));

	memory_space_decoder memory_space_decoder_i (.core_clk_in, .rst_b_in, .addr_in(addr),
		.wdata_in(wdata), .write_strobe_in(wr_s), .read_strobe_in(rd_s), .code_fetch_strobe_in(cf_s),
		.bus_control_inputs_in(ctl), .twenty_bit_mode_in(twenty), .power_down_input_in(pwr_down),
		.port_a_in(pa), .port_b_in(pa), .port_c_in(pa), .port_d_in(pa[2:0]),
		.port_ab_cell_feedback_in(pa), .port_bc_cell_feedback_in(pa), .eeprom_ready_in(ready),
		.config_space_base_in(16'h0200), .flash_care_in(fl_care), .flash_match_in(fl_match),
		.flash_term_en_in(fl_en), .eeprom_care_in(ee_care), .eeprom_match_in(ee_match),
		.eeprom_term_en_in(ee_en), .sram_care_in(sr_care), .sram_match_in(sr_match),
		.sram_term_en_in(sr_en), .misc_care_in(mi_care), .misc_match_in(mi_match), .rdata_out(rdata),
		.flash_sector_select_out(fl_sel), .eeprom_sector_select_out(ee_sel), .sram_select_out(sr_sel),
		.config_select_out(cfg_sel), .jtag_enable_out(jtag), .peripheral_select_out(per_sel),
		.array_bus_out(abus), .arrays_standby_out(standby));

	task automatic note(input string s);
		$display("test %s ended, errors %0d", s, num_errors);
	endtask : note

	task automatic wrap_up();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : wrap_up

	// a hang counts as a mismatch
	always @(posedge core_clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			wrap_up();
		end
	end

	// ==========================================
	// main sequence
	initial begin
		{fl_care[72], fl_match[72], fl_en[0]} = 3'b111;
		{ee_care[72:71], ee_match[72:71], ee_en[0]} = 5'b11101;
		{sr_care[72:68], sr_match[72:68], sr_en[0]} = 11'h7E1;
		mi_match[146] = 1'b1;
		repeat (2) @(negedge core_clk_in);
		rst_b_in = 1'b1;
		foreach (rows[i]) begin
			mcu_bus_model_i.access(2'd3, 20'h002E1, rows[i].map, d);
			mcu_bus_model_i.access(rows[i].kind, {4'h0, rows[i].addr}, 8'h00, d);
			`CHK({sr_sel, ee_sel[0], fl_sel[0], cfg_sel}, {rows[i].exp, 1'b0})
		end
		note("space map rows");
		rst_b_in = 1'b0;
		@(negedge core_clk_in);
		`CHK({fl_sel, ee_sel, sr_sel, cfg_sel, jtag, standby, rdata}, 24'h000000)
		@(negedge core_clk_in);
		rst_b_in = 1'b1;
		foreach (roff[i]) begin
			mcu_bus_model_i.access(2'd2, {12'h002, roff[i]}, 8'h00, d);
			`CHK(d, rval[i])
		end
		repeat (20) @(negedge core_clk_in);
		`CHK({standby, jtag}, 2'b01)
		ready = 1'b0;
		repeat (2) @(negedge core_clk_in);
		`CHK(jtag, 1'b0)
		`CHK(per_sel, 2'b00)
		ready = 1'b1;
		note("reset values");
		mcu_bus_model_i.access(2'd3, 20'h002E0, 8'hA5, d);
		mcu_bus_model_i.access(2'd3, 20'h003E0, 8'h5A, d);
		mcu_bus_model_i.access(2'd2, 20'h002E0, 8'h00, d);
		`CHK(d, 8'hA5)
		`CHK(cfg_sel, 1'b1)
		`CHK(abus[24:17], 8'hA5)
		mcu_bus_model_i.access(2'd3, 20'h002E1, 8'hFF, d);
		mcu_bus_model_i.access(2'd2, 20'h002E1, 8'h00, d);
		`CHK(d, 8'h9F)
		ready = 1'b0;
		repeat (2) @(negedge core_clk_in);
		`CHK(per_sel, 2'b11)
		ready = 1'b1;
		mcu_bus_model_i.access(2'd3, 20'h002E5, 8'h33, d);
		mcu_bus_model_i.access(2'd2, 20'h002E5, 8'h00, d);
		`CHK(d, 8'h00)
		note("registers");
		twenty = 1'b1;
		mcu_bus_model_i.access(2'd0, 20'hABCDE, 8'h00, d);
		`CHK(abus[72:57], 16'hABCD)
		twenty = 1'b0;
		mcu_bus_model_i.access(2'd0, 20'hABCDE, 8'h00, d);
		`CHK(abus[72:57], 16'hBCDE)
		{ctl, pwr_down} = 4'hF;
		mcu_bus_model_i.access(2'd3, 20'h002B4, 8'h1F, d);
		mcu_bus_model_i.access(2'd0, 20'h00000, 8'h00, d);
		`CHK({abus[56:54], abus[52]}, 4'h0)
		mcu_bus_model_i.access(2'd3, 20'h002B4, 8'h00, d);
		mcu_bus_model_i.access(2'd0, 20'h00000, 8'h00, d);
		`CHK({abus[56:54], abus[52]}, 4'hF)
		note("array bus");
		mcu_bus_model_i.access(2'd3, 20'h002B0, 8'h00, d);
		repeat (20) @(negedge core_clk_in);
		`CHK(standby, 1'b1)
		pa = 8'h5A;
		repeat (2) @(negedge core_clk_in);
		`CHK(standby, 1'b0)
		note("standby");
		wrap_up();
	end
endmodule : tb_memory_space_decoder

// file: core/memory_space_decoder.sv
// decode array, space map, page and power-mode registers
`timescale 1ns/1ps
`include "memory_space_decoder_params.svh"
module memory_space_decoder
	import memory_space_decoder_pkg::*;
(
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	// processor bus
	input wire logic [19:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic write_strobe_in,
	input wire logic read_strobe_in,
	input wire logic code_fetch_strobe_in,
	input wire logic [2:0] bus_control_inputs_in,
	input wire logic twenty_bit_mode_in,
	// other array inputs
	input wire logic power_down_input_in,
	input wire logic [7:0] port_a_in,
	input wire logic [7:0] port_b_in,
	input wire logic [7:0] port_c_in,
	input wire logic [2:0] port_d_in,
	input wire logic [7:0] port_ab_cell_feedback_in,
	input wire logic [7:0] port_bc_cell_feedback_in,
	input wire logic eeprom_ready_in,
	// programmed equations, fixed by configuration
	input wire logic [15:0] config_space_base_in,
	input wire logic [8*3*73-1:0] flash_care_in,
	input wire logic [8*3*73-1:0] flash_match_in,
	input wire logic [8*3-1:0] flash_term_en_in,
	input wire logic [4*3*73-1:0] eeprom_care_in,
	input wire logic [4*3*73-1:0] eeprom_match_in,
	input wire logic [4*3-1:0] eeprom_term_en_in,
	input wire logic [2*73-1:0] sram_care_in,
	input wire logic [2*73-1:0] sram_match_in,
	input wire logic [1:0] sram_term_en_in,
	input wire logic [4*73-1:0] misc_care_in,
	input wire logic [4*73-1:0] misc_match_in,
	// register read data
	output logic [7:0] rdata_out,
	// selects
	output logic [7:0] flash_sector_select_out,
	output logic [3:0] eeprom_sector_select_out,
	output logic sram_select_out,
	output logic config_select_out,
	output logic jtag_enable_out,
	output logic [1:0] peripheral_select_out,
	// to general logic array
	output logic [72:0] array_bus_out,
	output logic arrays_standby_out
);
	// ==========================================================
	// input bus
	logic [7:0] page_bits;
	logic [7:0] memory_space_map;
	logic [7:0] power_mode_reg_zero;
	logic [7:0] power_mode_reg_two;
	logic [15:0] dec_addr;
	logic [2:0] ctl_gated;
	input_bus_t bus;
	always_comb begin
		dec_addr = twenty_bit_mode_in ? addr_in[19:4] : addr_in[15:0]; // [R12]
		ctl_gated = bus_control_inputs_in & ~power_mode_reg_two[2:0]; // [R10]
		bus = {dec_addr, ctl_gated, ~rst_b_in & ~power_mode_reg_two[3], // [R11]
			power_down_input_in & ~power_mode_reg_two[4], port_a_in, port_b_in,
			port_c_in, port_d_in, page_bits, port_ab_cell_feedback_in, // [R7]
			port_bc_cell_feedback_in, eeprom_ready_in};
	end

	// ==========================================================
	// raw product-term selects
	logic [7:0] fl_raw;
	logic [3:0] ee_raw;
	logic sram_raw;
	logic [3:0] misc_raw;
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_fl
			product_term_select #(.TERMS(3)) u_fl ( // [R13]
				.bus_in(bus),
				.care_in(flash_care_in[g*219 +: 219]),
				.match_in(flash_match_in[g*219 +: 219]),
				.term_en_in(flash_term_en_in[g*3 +: 3]),
				.select_out(fl_raw[g])
			);
		end
		for (g = 0; g < 4; g++) begin : g_ee
			product_term_select #(.TERMS(3)) u_ee ( // [R14]
				.bus_in(bus),
				.care_in(eeprom_care_in[g*219 +: 219]),
				.match_in(eeprom_match_in[g*219 +: 219]),
				.term_en_in(eeprom_term_en_in[g*3 +: 3]),
				.select_out(ee_raw[g])
			);
			product_term_select #(.TERMS(1)) u_misc (
				.bus_in(bus),
				.care_in(misc_care_in[g*73 +: 73]),
				.match_in(misc_match_in[g*73 +: 73]),
				.term_en_in(1'b1),
				.select_out(misc_raw[g])
			);
		end
	endgenerate
	product_term_select #(.TERMS(2)) u_sram ( // [R15]
		.bus_in(bus),
		.care_in(sram_care_in),
		.match_in(sram_match_in),
		.term_en_in(sram_term_en_in),
		.select_out(sram_raw)
	);

	// ==========================================================
	// space gating and priority
	logic code_cyc;
	logic data_cyc;
	logic cfg_hit;
	logic sram_sel;
	logic [1:0] pio_sel;
	logic high_win;
	logic [3:0] ee_sel;
	logic [7:0] fl_sel;
	always_comb begin
		code_cyc = code_fetch_strobe_in;
		data_cyc = read_strobe_in | write_strobe_in;
		// config space is a 256-byte block at a programmed base, matched on A15-A8 in any cycle
		cfg_hit = (addr_in[15:8] == config_space_base_in[15:8]); // [R16]
		// sram sits in data space always; an idle cycle is in neither space
		sram_sel = sram_raw & ((code_cyc & memory_space_map[`BIT_SRAM_CODE]) | data_cyc); // [R1] [R20] [R22]
		pio_sel = misc_raw[1:0] & {2{memory_space_map[`BIT_PERIPH_IO]}}; // [R18] [R20]
		high_win = sram_sel | cfg_hit | (|pio_sel); // [R21]
		ee_sel = ee_raw & {4{~high_win}} & {4{(code_cyc & memory_space_map[`BIT_EEPROM_CODE]) |
			(data_cyc & memory_space_map[`BIT_EEPROM_DATA])}}; // [R1] [R3] [R20] [R21]
		fl_sel = fl_raw & {8{~high_win & ~(|ee_sel)}} &
			{8{(code_cyc & memory_space_map[`BIT_FLASH_CODE]) |
			(data_cyc & memory_space_map[`BIT_FLASH_DATA])}}; // [R1] [R4] [R20] [R21]
	end

	// ==========================================================
	// registers
	logic [7:0] next_page_bits;
	logic [7:0] next_memory_space_map;
	logic [7:0] next_power_mode_reg_zero;
	logic [7:0] next_power_mode_reg_two;
	logic [7:0] next_rdata;
	logic wr_cfg;
	logic [7:0] reg_off;
	always_comb begin
		reg_off = addr_in[7:0];
		wr_cfg = write_strobe_in & cfg_hit;
		next_page_bits = page_bits;
		next_memory_space_map = memory_space_map;
		next_power_mode_reg_zero = power_mode_reg_zero;
		next_power_mode_reg_two = power_mode_reg_two;
		next_rdata = 8'h00;
		if (wr_cfg) begin
			case (reg_off)
				`PAGE_OFFSET: next_page_bits = wdata_in; // [R5] [R6]
				`SPACE_MAP_OFFSET: next_memory_space_map = wdata_in & `SPACE_MAP_USED; // [R2]
				`PMR0_OFFSET: next_power_mode_reg_zero = wdata_in;
				`PMR2_OFFSET: next_power_mode_reg_two = {3'h0, wdata_in[4:0]}; // [R10]
				default: next_page_bits = page_bits;
			endcase
		end
		if (read_strobe_in & cfg_hit) begin
			case (reg_off)
				`PAGE_OFFSET: next_rdata = page_bits; // [R5]
				`SPACE_MAP_OFFSET: next_rdata = memory_space_map;
				`PMR0_OFFSET: next_rdata = power_mode_reg_zero;
				`PMR2_OFFSET: next_rdata = power_mode_reg_two;
				default: next_rdata = 8'h00;
			endcase
		end
	end
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			page_bits <= `PAGE_RESET; // [R23]
			memory_space_map <= `SPACE_MAP_BOOT; // [R2] [R19]
			power_mode_reg_zero <= `PMR0_RESET;
			power_mode_reg_two <= `PMR2_RESET;
			rdata_out <= 8'h00;
		end else begin
			page_bits <= next_page_bits;
			memory_space_map <= next_memory_space_map;
			power_mode_reg_zero <= next_power_mode_reg_zero;
			power_mode_reg_two <= next_power_mode_reg_two;
			rdata_out <= next_rdata;
		end
	end

	// ==========================================================
	// standby detect: idle counter on the array input bus
	logic [3:0] idle_cnt;
	logic [3:0] next_idle_cnt;
	input_bus_t bus_prev;
	logic next_standby;
	always_comb begin
		next_idle_cnt = idle_cnt;
		if (bus != bus_prev || power_mode_reg_zero[`BIT_FULL_SPEED]) begin
			next_idle_cnt = 4'h0; // [R9]
		end else if (idle_cnt < 4'(`IDLE_CYCLES)) begin
			next_idle_cnt = idle_cnt + 4'h1;
		end
		next_standby = ~power_mode_reg_zero[`BIT_FULL_SPEED] && next_idle_cnt == 4'(`IDLE_CYCLES); // [R9]
	end

	// ==========================================================
	// outputs, registered (one cycle after the bus settles)
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			idle_cnt <= 4'h0;
			bus_prev <= '0;
			arrays_standby_out <= 1'b0;
			flash_sector_select_out <= 8'h00;
			eeprom_sector_select_out <= 4'h0;
			sram_select_out <= 1'b0;
			config_select_out <= 1'b0;
			jtag_enable_out <= 1'b0;
			peripheral_select_out <= 2'h0;
			array_bus_out <= '0;
		end else begin
			idle_cnt <= next_idle_cnt;
			bus_prev <= bus;
			arrays_standby_out <= next_standby;
			flash_sector_select_out <= fl_sel; // [R23]
			eeprom_sector_select_out <= ee_sel;
			sram_select_out <= sram_sel; // [R22]
			config_select_out <= cfg_hit;
			jtag_enable_out <= misc_raw[2]; // [R17]
			peripheral_select_out <= pio_sel;
			array_bus_out <= bus; // [R8]
		end
	end

	// ==========================================================
	// checks
	a_flash_below_ee: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [R21]
		|eeprom_sector_select_out |-> flash_sector_select_out == 8'h00) else $error("flash and eeprom both selected");
	a_ee_below_sram: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [R21]
		sram_select_out |-> eeprom_sector_select_out == 4'h0) else $error("sram and eeprom both selected");
	a_page_write: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [R5]
		wr_cfg && reg_off == `PAGE_OFFSET |=> page_bits == $past(wdata_in)) else $error("page write lost");
	a_page_on_bus: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [R7]
		##1 array_bus_out[24:17] == $past(page_bits)) else $error("page bits missing from bus");
	a_map_update: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [R2]
		wr_cfg && reg_off == `SPACE_MAP_OFFSET |=> memory_space_map == ($past(wdata_in) & `SPACE_MAP_USED))
		else $error("map write");
	a_flash_code_gate: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [R4]
		code_cyc && !data_cyc && !memory_space_map[`BIT_FLASH_CODE] |=> flash_sector_select_out == 8'h00)
		else $error("flash code leak");
	a_sram_idle: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [R1]
		!code_cyc && !data_cyc |=> !sram_select_out) else $error("sram selected on idle cycle");
	a_pio_gate: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [R18]
		!memory_space_map[`BIT_PERIPH_IO] |=> peripheral_select_out == 2'h0) else $error("pio select while disabled");
	a_standby_fast: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [R9]
		power_mode_reg_zero[`BIT_FULL_SPEED] |=> !arrays_standby_out) else $error("standby in full speed");
	a_ctl_block: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // [R10]
		power_mode_reg_two[0] |-> !bus[54]) else $error("blocked control reached array");
endmodule : memory_space_decoder

// file: core/product_term_select.sv
// one select formed as the or of several product terms
`timescale 1ns/1ps
module product_term_select #(
	parameter int TERMS = 3
) (
	// bus
	input wire logic [72:0] bus_in,
	// programmed terms
	input wire logic [TERMS*73-1:0] care_in,
	input wire logic [TERMS*73-1:0] match_in,
	input wire logic [TERMS-1:0] term_en_in,
	// result
	output logic select_out
);
	logic [TERMS-1:0] hit;
	always_comb begin
		for (int t = 0; t < TERMS; t++) begin
			hit[t] = term_en_in[t] && (((bus_in ^ match_in[t*73 +: 73]) & care_in[t*73 +: 73]) == '0);
		end
		select_out = |hit;
	end
endmodule : product_term_select

// file: shared/memory_space_decoder_params.svh
// constants for the memory space decoder
// How it works
// R1: each memory placed in code space, data space or both per space map.
// R2: space map boots to configured value; processor rewrites take effect at once.
// R3: software writes 0Ch for separate spaces: flash code, others data.
// R4: space map bits 2 and 4 set put flash in both spaces.
// R5: eight-bit page register written and read back on data lines.
// R6: page register sits at config space base plus E0h.
// R7: all page bits feed the decode array, giving 256 pages.
// R8: unused page bits are offered to the general logic array.
// R9: full-speed bit off lets arrays sleep after about 70ns idle.
// R10: five power-mode-two bits block processor control signals from arrays.
// R11: array input bus carries 73 signals in the documented grouping.
// R12: twenty-bit mode feeds address lines A19-A4 into the array.
// R13: eight flash sector selects, up to three product terms each.
// R14: four eeprom sector selects, up to three product terms each.
// R15: one sram select from up to two product terms.
// R16: one select enables the configuration register space.
// R17: one jtag select enables jtag on port C.
// R18: two peripheral selects, used in peripheral io mode.
// R19: programmed decode is active from power-up without processor action.
// R20: space map bit meanings: 0 sram,1 eeprom,2 flash code; 3,4 data; 7 pio.
// R21: sram, io, peripheral beat eeprom; eeprom beats flash.
// R22: sram enabled only while its select is high.
// R23: selects are combinational decodes; page register clears on reset. The selects are registered here, one cycle after the decode.
`ifndef MEMORY_SPACE_DECODER_PARAMS_SVH
`define MEMORY_SPACE_DECODER_PARAMS_SVH
`define PAGE_OFFSET 8'hE0
`define SPACE_MAP_OFFSET 8'hE1
`define PMR0_OFFSET 8'hB0
`define PMR2_OFFSET 8'hB4
`define SPACE_MAP_BOOT 8'h0C
`define PAGE_RESET 8'h00
`define PMR0_RESET 8'h08
`define PMR2_RESET 8'h00
`define BIT_SRAM_CODE 0
`define BIT_EEPROM_CODE 1
`define BIT_FLASH_CODE 2
`define BIT_EEPROM_DATA 3
`define BIT_FLASH_DATA 4
`define BIT_PERIPH_IO 7
`define BIT_FULL_SPEED 3
`define SPACE_MAP_USED 8'h9F
`define IDLE_NS 70
`define CLK_NS 8
`define IDLE_CYCLES ((`IDLE_NS + `CLK_NS - 1) / `CLK_NS)
`define BUS_WIDTH 73
`endif

// file: shared/memory_space_decoder_pkg.sv
// types for the memory space decoder
package memory_space_decoder_pkg;
	typedef logic [72:0] input_bus_t;
	typedef logic [7:0] byte_t;
	typedef enum logic [1:0] {
		grant_none,
		grant_flash,
		grant_eeprom,
		grant_high
	} grant_t;
endpackage : memory_space_decoder_pkg
